// file: design/scw_dev.sv
// Gate driver serial port, watchdog, fault response and sleep control
`timescale 1ns/100ps
module scw_dev #(
	parameter int unsigned WD_BASE_CYCLES   = scw_pkg::WD_BASE_CYC,
	parameter int unsigned WDA_PULSE_CYCLES = scw_pkg::WDA_PULSE_CYC
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Serial link
	scw_if.dev              link,
	// Fault monitors, same clock domain
	input  wire logic       ocp_event,
	input  wire logic       gate_drive_error,
	input  wire logic       vm_undervolt,
	input  wire logic       vcp_undervolt,
	input  wire logic       overtemp_shutdown,
	input  wire logic       overtemp_warning_flag,
	input  wire logic [7:0] fet_diag,
	// Pins from outside the clock domain
	input  wire logic       sleep_pin_n,
	input  wire logic [1:0] mode_pins,
	// Driver control and alarms
	output logic            watchdog_alarm_pin_n,
	output logic            alarm_pin_n,
	output logic            driver_enable,
	output logic            gate_pulldown,
	output logic            charge_pump_enable,
	output logic            regulator_enable,
	output logic            frame_error,
	output logic [1:0]      input_mode,
	// Settings
	output logic [7:0]      cfg_main,
	output logic [7:0]      cfg_drive_wd,
	output logic [7:0]      cfg_vds,
	output logic [7:0]      cfg_config
);
	import scw_pkg::*;

	logic [SYNC_W-1:0] s1, s2, s3, filt, filt_q;
	logic [SYNC_W-1:0] pin_in;
	logic [15:0]       sh;
	logic [4:0]        fcnt;
	logic              rw_q;
	logic [7:0]        snap;
	logic [7:0]        stat_flags;
	logic [7:0]        diag;
	logic [31:0]       wd_cnt;
	logic [15:0]       pulse_cnt;
	logic [15:0]       retry_cnt;
	logic [15:0]       slp_cnt;
	logic [2:0]        boot_cnt;
	scw_sleep_e        slp;
	logic              cs_act, sclk_fall, sclk_rise, cs_fall, cs_rise, full;
	logic              commit_wr, kick, clr_pulse, watchdog_enable_bit, wd_expire, wake_start, retry_trig;
	logic [3:0]        f_addr;
	logic [7:0]        status_rd;
	logic [4:0]        out_idx;
	logic [31:0]       wd_limit;

	// Raw pin lanes, gathered so each synchroniser lane reads one bit
	assign pin_in = {mode_pins, sleep_pin_n, link.sdi, link.sclk, link.chip_select_n};

	// Three-stage synchronisers; a change counts once stages two and three agree
	generate
		for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					s1[i]     <= SYNC_RST[i];
					s2[i]     <= SYNC_RST[i];
					s3[i]     <= SYNC_RST[i];
					filt[i]   <= SYNC_RST[i];
					filt_q[i] <= SYNC_RST[i];
				end else begin
					s1[i]     <= pin_in[i];
					s2[i]     <= s1[i];
					s3[i]     <= s2[i];
					filt[i]   <= (s2[i] == s3[i]) ? s3[i] : filt[i];
					filt_q[i] <= filt[i];
				end
			end
		end
	endgenerate

	// Link edges; clock and data are ignored while deselected
	assign cs_act    = ~filt[0];
	assign cs_fall   = filt_q[0] & ~filt[0];
	assign cs_rise   = ~filt_q[0] & filt[0];
	assign sclk_fall = cs_act & ~cs_fall & filt_q[1] & ~filt[1];
	assign sclk_rise = cs_act & ~filt_q[1] & filt[1];
	assign full      = (fcnt == FRAME_BITS);
	assign f_addr    = sh[ADDR_MSB:ADDR_LSB];
	assign commit_wr = cs_rise & full & ~sh[RW_BIT];
	assign kick      = cs_rise & full & sh[RW_BIT] & (f_addr == ADDR_STATUS);
	assign clr_pulse = commit_wr & (f_addr == ADDR_MAIN) & sh[CLR_POS];
	assign watchdog_enable_bit     = cfg_drive_wd[WDEN_POS];
	assign out_idx   = LAST_BIT - fcnt;
	assign wd_limit  = WD_BASE_CYCLES << cfg_drive_wd[WDDLY_LSB+:2];
	assign wd_expire = watchdog_enable_bit & (wd_cnt == 32'h0000_0000) & ~kick;
	assign wake_start = (slp == SLP_DOWN) & filt[3];
	assign retry_trig = (ocp_event | gate_drive_error) & (retry_cnt == 16'h0000);

	// Status word: summary bit covers every fault but the warning
	always_comb begin
		status_rd           = stat_flags;
		status_rd[STAT_ANY] = |stat_flags[STAT_WD:1];
	end

	// Register read view
	function automatic logic [7:0] reg_value(input logic [3:0] a);
		unique case (a)
			ADDR_STATUS: reg_value = status_rd;
			ADDR_DIAG:   reg_value = diag;
			ADDR_MAIN:   reg_value = cfg_main;
			ADDR_DRVWD:  reg_value = cfg_drive_wd;
			ADDR_VDS:    reg_value = cfg_vds;
			ADDR_CONFIG: reg_value = cfg_config;
			default:     reg_value = 8'h00;
		endcase
	endfunction : reg_value

	// Receive shifter and bit counter, MSB first on falling clock
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sh   <= 16'h0000;
			fcnt <= 5'h00;
			rw_q <= 1'b0;
		end else if (cs_fall) begin
			sh   <= 16'h0000;
			fcnt <= 5'h00;
		end else if (sclk_fall) begin
			sh   <= {sh[14:0], filt[2]};
			fcnt <= (fcnt == FCNT_MAX) ? fcnt : fcnt + 5'h01;      // Saturate so long frames stay wrong
			if (fcnt == 5'h00)
				rw_q <= filt[2];
		end
	end

	// Transmit side: don't-care zeros, then the register as it stood after the command
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			snap     <= 8'h00;
			link.sdo <= 1'b0;
		end else if (cs_fall) begin
			link.sdo <= 1'b0;
		end else if (sclk_rise) begin
			if (fcnt == CMD_BITS)
				snap <= reg_value(sh[3:0]);
			if (fcnt >= DATA_START && fcnt <= LAST_BIT)
				link.sdo <= snap[out_idx[2:0]];
			else
				link.sdo <= 1'b0;
		end
	end

	// Output released whenever deselected
	assign link.sdo_oe_n = filt[0];

	// Frame error pulse on a short or long write; the write is dropped
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			frame_error <= 1'b0;
		else
			frame_error <= cs_rise & (fcnt != 5'h00) & ~rw_q & ~full;
	end

	// Settings; defaults again on wake, expiry drops the watchdog enable
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_main     <= MAIN_RST;
			cfg_drive_wd <= DRVWD_RST;
			cfg_vds      <= VDS_RST;
			cfg_config   <= CONFIG_RST;
		end else if (wake_start) begin
			cfg_main     <= MAIN_RST;
			cfg_drive_wd <= DRVWD_RST;
			cfg_vds      <= VDS_RST;
			cfg_config   <= CONFIG_RST;
		end else begin
			if (commit_wr) begin
				unique case (f_addr)
					ADDR_MAIN:   cfg_main     <= {sh[DATA_MSB:1], 1'b0}; // Clear bit never stays set
					ADDR_DRVWD:  cfg_drive_wd <= sh[DATA_MSB:0];
					ADDR_VDS:    cfg_vds      <= sh[DATA_MSB:0];
					ADDR_CONFIG: cfg_config   <= sh[DATA_MSB:0];
					default:     ;
				endcase
			end
			if (wd_expire)
				cfg_drive_wd[WDEN_POS] <= 1'b0;
		end
	end

	// Sticky fault flags; a new event wins over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stat_flags <= 8'h00;
			diag       <= 8'h00;
		end else begin
			stat_flags <= {1'b0, wd_expire, gate_drive_error, ocp_event, vm_undervolt, vcp_undervolt,
			               overtemp_shutdown, overtemp_warning_flag} | (clr_pulse ? 8'h00 : stat_flags);
			diag       <= fet_diag | (clr_pulse ? 8'h00 : diag);
		end
	end

	// Watchdog countdown, reloaded while off and on each valid status read
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			wd_cnt <= 32'h0000_0000;
		else if (!watchdog_enable_bit || kick)
			wd_cnt <= wd_limit;
		else if (wd_cnt != 32'h0000_0000)
			wd_cnt <= wd_cnt - 32'h0000_0001;
	end

	// Watchdog alarm pulse length
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			pulse_cnt <= 16'h0000;
		else if (wd_expire)
			pulse_cnt <= 16'(WDA_PULSE_CYCLES);
		else if (pulse_cnt != 16'h0000)
			pulse_cnt <= pulse_cnt - 16'h0001;
	end

	// Retry timer after gate drive or overcurrent; repeats if the fault persists
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			retry_cnt <= 16'h0000;
		else if (retry_trig)
			retry_cnt <= 16'(RETRY_CYC);
		else if (retry_cnt != 16'h0000)
			retry_cnt <= retry_cnt - 16'h0001;
	end

	// Sleep sequencing; a short low pulse on the pin never reaches sleep
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			slp     <= SLP_RUN;
			slp_cnt <= 16'h0000;
		end else begin
			unique case (slp)
				SLP_RUN: if (!filt[3]) begin
					slp     <= SLP_ENTER;
					slp_cnt <= 16'(SLEEP_CYC);
				end
				SLP_ENTER: if (filt[3]) begin
					slp <= SLP_RUN;
				end else if (slp_cnt == 16'h0001) begin
					slp <= SLP_DOWN;
				end else begin
					slp_cnt <= slp_cnt - 16'h0001;
				end
				SLP_DOWN: if (filt[3]) begin
					slp     <= SLP_WAKE;
					slp_cnt <= 16'(WAKE_CYC);
				end
				SLP_WAKE: if (slp_cnt == 16'h0001) begin
					slp <= SLP_RUN;
				end else begin
					slp_cnt <= slp_cnt - 16'h0001;
				end
			endcase
		end
	end

	// Input mode capture once after power-up and at each wake
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			boot_cnt   <= 3'h0;
			input_mode <= 2'h0;
		end else begin
			if (boot_cnt != BOOT_CYC)
				boot_cnt <= boot_cnt + 3'h1;
			if (boot_cnt == BOOT_CYC - 3'h1 || wake_start)
				input_mode <= filt[5:4];
		end
	end

	// Registered driver controls; driver stays off through the wake delay, while charge pump and regulator come back on at wake start
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			driver_enable        <= 1'b0;
			gate_pulldown        <= 1'b1;
			charge_pump_enable   <= 1'b0;
			regulator_enable     <= 1'b0;
			alarm_pin_n          <= 1'b1;
			watchdog_alarm_pin_n <= 1'b1;
		end else begin
			driver_enable        <= (slp == SLP_RUN) & ~stat_flags[STAT_WD] & ~wd_expire & (retry_cnt == 16'h0000)
			                        & ~retry_trig & ~vm_undervolt & ~vcp_undervolt & ~overtemp_shutdown;
			// Gates stay pulled off until the wake delay has run out
			gate_pulldown        <= ~filt[3] | (slp == SLP_DOWN) | (slp == SLP_WAKE);
			charge_pump_enable   <= (slp != SLP_DOWN) & ~vm_undervolt & ~overtemp_shutdown;
			regulator_enable     <= (slp != SLP_DOWN) & ~vm_undervolt & ~overtemp_shutdown;
			alarm_pin_n          <= ~(stat_flags[STAT_WD] | wd_expire | (retry_cnt != 16'h0000) | vm_undervolt
			                        | vcp_undervolt | overtemp_shutdown);
			watchdog_alarm_pin_n <= ~(wd_expire | (pulse_cnt > 16'h0001));
		end
	end

endmodule : scw_dev

// file: design/scw_pkg.sv
// Shared constants and types for the serial configuration and watchdog block
package scw_pkg;

	// Clock and timing
	localparam int SYS_PERIOD_NS  = 4;
	localparam int WDA_PULSE_NS   = 64000;
	localparam int WDA_PULSE_CYC  = WDA_PULSE_NS / SYS_PERIOD_NS;
	localparam int WD_BASE_NS     = 10000000;
	localparam int WD_BASE_CYC    = WD_BASE_NS / SYS_PERIOD_NS;
	localparam int SLEEP_NS       = 1000;
	localparam int SLEEP_CYC      = (SLEEP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int WAKE_NS        = 1000;
	localparam int WAKE_CYC       = (WAKE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int RETRY_NS       = 3000;
	localparam int RETRY_CYC      = (RETRY_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int GAP_NS         = 500;
	localparam int GAP_CYC        = (GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int SCLK_HALF_CYC  = 16;
	localparam logic [2:0] BOOT_CYC = 3'h5;

	// Frame layout
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] FCNT_MAX   = 5'h11;
	localparam logic [4:0] CMD_BITS   = 5'h05;
	localparam logic [4:0] DATA_START = 5'h08;
	localparam logic [4:0] LAST_BIT   = 5'h0F;
	localparam int RW_BIT   = 15;
	localparam int ADDR_MSB = 14;
	localparam int ADDR_LSB = 11;
	localparam int DATA_MSB = 7;

	// Device register map
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_DIAG   = 4'h1;
	localparam logic [3:0] ADDR_MAIN   = 4'h2;
	localparam logic [3:0] ADDR_DRVWD  = 4'h3;
	localparam logic [3:0] ADDR_VDS    = 4'h4;
	localparam logic [3:0] ADDR_CONFIG = 4'h5;
	localparam int CLR_POS    = 0;
	localparam int WDEN_POS   = 5;
	localparam int WDDLY_LSB  = 3;
	localparam int STAT_ANY   = 7;
	localparam int STAT_WD    = 6;
	localparam logic [7:0] MAIN_RST   = 8'h18;
	localparam logic [7:0] DRVWD_RST  = 8'h00;
	localparam logic [7:0] VDS_RST    = 8'h00;
	localparam logic [7:0] CONFIG_RST = 8'h00;

	// Synchroniser lanes: cs, sclk, sdi, sleep, mode[1:0]
	localparam int SYNC_W = 6;
	localparam logic [5:0] SYNC_RST = 6'h09;

	// Host command registers
	localparam logic [1:0] HREG_TX   = 2'h0;
	localparam logic [1:0] HREG_STAT = 2'h1;
	localparam logic [1:0] HREG_RX   = 2'h2;
	localparam logic [1:0] HREG_BITS = 2'h3;
	localparam logic [4:0] BITS_RST  = 5'h10;

	typedef enum logic [1:0] {
		SLP_RUN   = 2'b00,
		SLP_ENTER = 2'b01,
		SLP_DOWN  = 2'b11,
		SLP_WAKE  = 2'b10
	} scw_sleep_e;

	typedef enum logic [2:0] {
		HST_IDLE  = 3'b000,
		HST_LEAD  = 3'b001,
		HST_HIGH  = 3'b011,
		HST_LOW   = 3'b010,
		HST_TRAIL = 3'b110,
		HST_GAP   = 3'b100
	} scw_host_e;

endpackage : scw_pkg

// file: design/scw_if.sv
// Serial link between controller and gate driver configuration port
`timescale 1ns/100ps
interface scw_if;
	logic chip_select_n;
	logic sclk;
	logic sdi;
	logic sdo;
	logic sdo_oe_n;
	logic miso;

	// Undriven data line reads as low at the controller
	assign miso = ~sdo_oe_n & sdo;

	modport dev (input chip_select_n, input sclk, input sdi, output sdo, output sdo_oe_n);
	modport host (output chip_select_n, output sclk, output sdi, input miso);
endinterface : scw_if

// file: design/scw_host.sv
// Controller end: frames register commands onto the serial link
`timescale 1ns/100ps
module scw_host (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Serial link
	scw_if.host              link,
	// Command port
	input  wire logic [1:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata
);
	import scw_pkg::*;

	scw_host_e   st;
	logic [15:0] txs, rxs, rx_last;
	logic [4:0]  nbits, left;
	logic [7:0]  tcnt;
	logic        m1, m2, m3, mf;
	logic        busy, tick;

	assign busy = (st != HST_IDLE);
	assign tick = (tcnt == 8'h00);

	// Reply line synchroniser, change accepted when stages agree
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			m1 <= 1'b0;
			m2 <= 1'b0;
			m3 <= 1'b0;
			mf <= 1'b0;
		end else begin
			m1 <= link.miso;
			m2 <= m1;
			m3 <= m2;
			mf <= (m2 == m3) ? m3 : mf;
		end
	end

	// Frame length register; other lengths let software provoke a frame error
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			nbits <= BITS_RST;
		else if (wr && addr == HREG_BITS)
			nbits <= wdata[4:0];
	end

	// Read port, data one cycle after the strobe
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 16'h0000;
		end else if (rd) begin
			unique case (addr)
				HREG_TX:   rdata <= 16'h0000;
				HREG_STAT: rdata <= {15'h0000, busy};
				HREG_RX:   rdata <= rx_last;
				HREG_BITS: rdata <= {11'h000, nbits};
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end

	// Link sequencer: clock idles low, divider half period per phase, gap after select
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st                 <= HST_IDLE;
			tcnt               <= 8'h00;
			left               <= 5'h00;
			txs                <= 16'h0000;
			rxs                <= 16'h0000;
			rx_last            <= 16'h0000;
			link.chip_select_n <= 1'b1;
			link.sclk          <= 1'b0;
			link.sdi           <= 1'b0;
		end else begin
			if (!tick)
				tcnt <= tcnt - 8'h01;
			unique case (st)
				HST_IDLE: if (wr && addr == HREG_TX && nbits != 5'h00) begin
					st                 <= HST_LEAD;            // HREG_TX writes while busy are dropped
					link.chip_select_n <= 1'b0;
					link.sdi           <= wdata[RW_BIT];
					txs                <= {wdata[14:0], 1'b0};
					left               <= nbits;
					tcnt               <= 8'(SCLK_HALF_CYC - 1);
				end
				HST_LEAD: if (tick) begin
					st        <= HST_HIGH;
					link.sclk <= 1'b1;
					tcnt      <= 8'(SCLK_HALF_CYC - 1);
				end
				HST_HIGH: if (tick) begin
					st        <= HST_LOW;
					link.sclk <= 1'b0;
					rxs       <= {rxs[14:0], mf};
					left      <= left - 5'h01;
					tcnt      <= 8'(SCLK_HALF_CYC - 1);
				end
				HST_LOW: if (tick) begin
					if (left == 5'h00) begin
						st <= HST_TRAIL;
					end else begin
						st        <= HST_HIGH;
						link.sclk <= 1'b1;
						link.sdi  <= txs[15];
						txs       <= {txs[14:0], 1'b0};
					end
					tcnt <= 8'(SCLK_HALF_CYC - 1);
				end
				HST_TRAIL: if (tick) begin
					st                 <= HST_GAP;
					link.chip_select_n <= 1'b1;
					rx_last            <= rxs;
					tcnt               <= 8'(GAP_CYC - 1);
				end
				HST_GAP: if (tick) begin
					st <= HST_IDLE;
				end
				default: st <= HST_IDLE;
			endcase
		end
	end

endmodule : scw_host

// file: tb/scw_checker_assertions.sv
// Checker for the serial link between the controller and gate driver ends
`timescale 1ns/100ps
module scw_checker (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Link signals
	input wire logic chip_select_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe_n,
	input wire logic miso
);
	logic [7:0] gap_cnt;
	logic [7:0] rise_age;
	logic [4:0] fall_cnt;
	logic       sclk_q;
	logic       cs_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Delayed copies for edge detection
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
			cs_q   <= 1'b1;
		end else begin
			sclk_q <= sclk;
			cs_q   <= chip_select_n;
		end
	end
	// Idle cycles before a select; starts saturated so the first frame passes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) gap_cnt <= 8'hFF;
		else if (!chip_select_n) gap_cnt <= 8'h00;
		else if (gap_cnt != 8'hFF) gap_cnt <= gap_cnt + 8'h01;
	end
	// Cycles since the last clock rise or select fall
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) rise_age <= 8'hFF;
		else if ((sclk && !sclk_q) || (!chip_select_n && cs_q)) rise_age <= 8'h00;
		else if (rise_age != 8'hFF) rise_age <= rise_age + 8'h01;
	end
	// Falling clock edges within the current frame
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) fall_cnt <= 5'h00;
		else if (chip_select_n) fall_cnt <= 5'h00;
		else if (sclk_q && !sclk) fall_cnt <= fall_cnt + 5'h01;
	end

	a_cs_fall_clk: assert property ($fell(chip_select_n) |-> !sclk [*8])
		else $error("clock not low after select fall");
	a_cs_rise_clk: assert property ($rose(chip_select_n) |-> !sclk && !$past(sclk))
		else $error("clock not low at select rise");
	a_idle_clk_low: assert property (chip_select_n |-> !sclk)
		else $error("clock moved while deselected");
	a_select_gap: assert property ($fell(chip_select_n) |-> gap_cnt >= 8'd125)
		else $error("select gap too short");
	a_release_idle: assert property (chip_select_n [*6] |-> sdo_oe_n)
		else $error("data out driven while deselected");
	a_drive_sel: assert property (!chip_select_n [*6] |-> !sdo_oe_n)
		else $error("data out not driven in frame");
	a_sdo_after_rise: assert property (!chip_select_n && $changed(sdo) |-> rise_age <= 8'd8)
		else $error("data out changed away from a rise");
	a_head_zero: assert property (!chip_select_n && sclk_q && !sclk && fall_cnt < 5'd8 |-> !miso)
		else $error("reply head not zero");
	a_sdi_hold: assert property (!chip_select_n && sclk && sclk_q |-> $stable(sdi))
		else $error("data in moved while clock high");

	c_full_frame: cover property ($rose(chip_select_n) && fall_cnt == 5'd16);
	c_short_frame: cover property ($rose(chip_select_n) && fall_cnt == 5'd15);
	c_long_frame: cover property ($rose(chip_select_n) && fall_cnt == 5'd17);
endmodule : scw_checker

// file: tb/spi_config_watchdog_fault_ctrl_test.sv
// Testbench joining the controller and gate driver ends over the serial link
`timescale 1ns/100ps
module spi_config_watchdog_fault_ctrl_test;
	import scw_pkg::*;
	logic        clk_sys;
	logic        rst_n;
	logic [1:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        gate_drive_error;
	logic        ocp_event;
	logic        vm_undervolt;
	logic [7:0]  fet_diag;
	logic        overtemp_warning_flag;
	logic        sleep_pin_n;
	logic [1:0]  mode_pins;
	logic        watchdog_alarm_pin_n;
	logic        alarm_pin_n;
	logic        driver_enable;
	logic        gate_pulldown;
	logic        charge_pump_enable;
	logic        regulator_enable;
	logic        frame_error;
	logic [1:0]  input_mode;
	logic [7:0]  cfg_main;
	logic [7:0]  cfg_drive_wd;
	logic [7:0]  cfg_vds;
	logic [7:0]  cfg_config;
	logic [15:0] r;
	int          n_mismatch;
	int          num_checks;
	int          n_ferr;

	scw_if lnk ();
	scw_dev #(.WD_BASE_CYCLES(2000), .WDA_PULSE_CYCLES(40)) scw_dev_inst (.clk_sys, .rst_n, .link(lnk),
		.ocp_event, .gate_drive_error, .vm_undervolt, .vcp_undervolt(1'b0),
		.overtemp_shutdown(1'b0), .overtemp_warning_flag, .fet_diag, .sleep_pin_n, .mode_pins,
		.watchdog_alarm_pin_n, .alarm_pin_n, .driver_enable, .gate_pulldown, .charge_pump_enable,
		.regulator_enable, .frame_error, .input_mode, .cfg_main, .cfg_drive_wd, .cfg_vds, .cfg_config);
	scw_host scw_host_inst (.clk_sys, .rst_n, .link(lnk), .addr, .wdata, .wr, .rd, .rdata);
	scw_checker scw_checker_inst (.clk_sys, .rst_n, .chip_select_n(lnk.chip_select_n), .sclk(lnk.sclk),
		.sdi(lnk.sdi), .sdo(lnk.sdo), .sdo_oe_n(lnk.sdo_oe_n), .miso(lnk.miso));

	// Free-running system clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// Count frame error pulses; each stands one cycle
	always @(posedge clk_sys) if (frame_error === 1'b1) n_ferr++;

	task automatic test_done();
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic hw(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : hw

	task automatic hr(input logic [1:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		// Read data stand only in the cycle after the strobe; take them at its closing edge
		@(posedge clk_sys);
		d = rdata;
	endtask : hr

	// One whole frame; busy clears only after the select gap
	task automatic frame(input logic [15:0] w, output logic [15:0] q);
		logic [15:0] s;
		int          i;
		hw(HREG_TX, w);
		repeat (2) @(posedge clk_sys);
		s = 16'h0001;
		for (i = 0; i < 3000 && s[0] !== 1'b0; i++) hr(HREG_STAT, s);
		chk({15'h0000, s[0]}, 16'h0000);
		hr(HREG_RX, q);
	endtask : frame

	task automatic t_reset();
		chk({8'h00, cfg_main}, 16'h0018);
		chk({8'h00, cfg_drive_wd}, 16'h0000);
		chk({13'h0000, watchdog_alarm_pin_n, alarm_pin_n, driver_enable}, 16'h0007);
		chk({14'h0000, input_mode}, 16'h0001);
		$display("test reset done");
	endtask : t_reset

	task automatic t_access();
		frame(16'h2033, r);
		chk(r, 16'h0000);
		chk({8'h00, cfg_vds}, 16'h0033);
		frame(16'h2044, r);
		chk(r, 16'h0033);
		frame(16'hA000, r);
		chk(r, 16'h0044);
		chk({8'h00, cfg_vds}, 16'h0044);
		frame(16'h9000, r);
		chk(r, 16'h0018);
		$display("test access done");
	endtask : t_access

	task automatic t_frame_err();
		int e0;
		e0 = n_ferr;
		hw(HREG_BITS, 16'h000F);
		frame(16'h2055, r);
		hw(HREG_BITS, 16'h0011);
		frame(16'h2066, r);
		hw(HREG_BITS, 16'h0010);
		chk(16'(n_ferr - e0), 16'h0002);
		chk({8'h00, cfg_vds}, 16'h0044);
		$display("test frame error done");
	endtask : t_frame_err

	task automatic t_faults();
		overtemp_warning_flag <= 1'b1;
		frame(16'h8000, r);
		chk(r, 16'h0001);
		@(posedge clk_sys);
		gate_drive_error <= 1'b1;
		repeat (10) @(posedge clk_sys);
		gate_drive_error <= 1'b0;
		overtemp_warning_flag <= 1'b0;
		chk({14'h0000, driver_enable, charge_pump_enable}, 16'h0001);
		repeat (600) @(posedge clk_sys);
		chk({15'h0000, driver_enable}, 16'h0000);
		repeat (400) @(posedge clk_sys);
		chk({15'h0000, driver_enable}, 16'h0001);
		frame(16'h8000, r);
		chk(r, 16'h00A1);
		fet_diag <= 8'h5A;
		@(posedge clk_sys);
		fet_diag <= 8'h00;
		frame(16'h8800, r);
		chk(r, 16'h005A);
		frame(16'h1019, r);
		frame(16'h8000, r);
		chk(r, 16'h0000);
		frame(16'h8800, r);
		chk(r, 16'h0000);
		$display("test faults done");
	endtask : t_faults

	task automatic t_watchdog();
		int i;
		int n;
		frame(16'h1820, r);
		repeat (3) frame(16'h8000, r);
		chk({15'h0000, watchdog_alarm_pin_n}, 16'h0001);
		for (i = 0; i < 3000 && watchdog_alarm_pin_n !== 1'b0; i++) @(posedge clk_sys) #1;
		chk({15'h0000, i >= 1700 && i <= 2100}, 16'h0001);
		chk({14'h0000, alarm_pin_n, driver_enable}, 16'h0000);
		for (n = 0; n < 100 && watchdog_alarm_pin_n === 1'b0; n++) @(posedge clk_sys) #1;
		chk(16'(n), 16'd40);
		frame(16'h9800, r);
		chk(r, 16'h0000);
		frame(16'h8000, r);
		chk(r, 16'h00C0);
		chk({14'h0000, alarm_pin_n, driver_enable}, 16'h0000);
		frame(16'h1019, r);
		chk({14'h0000, alarm_pin_n, driver_enable}, 16'h0003);
		$display("test watchdog done");
	endtask : t_watchdog

	task automatic t_sleep();
		frame(16'h2855, r);
		mode_pins <= 2'b10;
		repeat (20) @(posedge clk_sys);
		chk({14'h0000, input_mode}, 16'h0001);
		sleep_pin_n <= 1'b0;
		repeat (150) @(posedge clk_sys);
		chk({15'h0000, charge_pump_enable}, 16'h0001);
		repeat (200) @(posedge clk_sys);
		chk({12'h000, charge_pump_enable, regulator_enable, gate_pulldown, driver_enable}, 16'h0002);
		sleep_pin_n <= 1'b1;
		repeat (100) @(posedge clk_sys);
		chk({13'h0000, charge_pump_enable, gate_pulldown, driver_enable}, 16'h0006);
		repeat (300) @(posedge clk_sys);
		chk({13'h0000, charge_pump_enable, regulator_enable, gate_pulldown}, 16'h0006);
		chk({8'h00, cfg_config}, 16'h0000);
		chk({14'h0000, input_mode}, 16'h0002);
		$display("test sleep done");
	endtask : t_sleep

	// Main sequence after a five-cycle reset
	initial begin
		n_mismatch = 0;
		num_checks = 0;
		n_ferr = 0;
		rst_n = 1'b0;
		addr = 2'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		gate_drive_error = 1'b0;
		ocp_event = 1'b0;
		vm_undervolt = 1'b0;
		fet_diag = 8'h00;
		overtemp_warning_flag = 1'b0;
		sleep_pin_n = 1'b1;
		mode_pins = 2'b01;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk_sys);
		t_reset();
		frame(16'h8000, r);
		t_access();
		t_frame_err();
		t_faults();
		t_watchdog();
		t_sleep();
		test_done();
	end
	// Hang guard, well beyond the expected run of about 18000 cycles
	initial begin
		#200000;
		n_mismatch++;
		test_done();
	end
endmodule : spi_config_watchdog_fault_ctrl_test
